// [core/mil_pkg.sv]
// Constants and types of the interrupt logic
//
// Functional notes
// R1: Any reset leaves every interrupt disabled.
// R2: Vector only with global and source enable.
// R3: Group enable also needed for peripheral sources.
// R4: Nine flag registers hold the source flags.
// R5: Accept: flush prefetch, clear global, push PC.
// R6: Save context to shadow, then load vector.
// R7: Global clear: flags still set, no vectoring.
// R8: Service routine clears handled flags first.
// R9: Return pops PC, restores context, sets global.
// R10: Flags set whatever any enable says.
// R11: Pending request served once global set again.
// R12: Requests sampled in first quarter-cycle only.
// R13: Pin-to-vector latency three to five cycles.
// R14: Pin flag set Q4-Q1, checked each Q1; code sets it in any phase.
// R15: Software polls flags to find the source.
// R16: Shadow keeps context except timeout/power-down bits.
// R17: First enable register needs no group enable.
// R18: Edge select picks rising or falling pin edge.
// R19: Flags stay latched until software clears them.
`default_nettype none
package mil_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_FLAG_REGS = 9;
	localparam int REG_W = 8;
	localparam int FLAG_W = NUM_FLAG_REGS * REG_W;
	localparam int PC_W = 15;
	localparam int CTX_W = 61;
	localparam int IDX_W = 12;
	localparam int STAT_W = 3;
	// ****************************************
	// Register indices, byte address is four times
	// ****************************************
	localparam logic [IDX_W-1:0] IDX_INTCTL = 12'h00b;
	localparam logic [IDX_W-1:0] IDX_FLAG0 = 12'h70c;
	localparam logic [IDX_W-1:0] IDX_EN0 = 12'h716;
	localparam logic [IDX_W-1:0] IDX_STAT = 12'h720;
	localparam logic [IDX_W-1:0] IDX_MASK = 12'h721;
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int GIE_BIT = 7;
	localparam int PERIPH_GROUP_IRQ_ENABLE_BIT = 6;
	localparam int EDGE_BIT = 0;
	localparam logic [REG_W-1:0] INTCTL_RST = 8'h01;
	localparam int ST_ACCEPT = 0;
	localparam int ST_RETURN = 1;
	localparam int ST_OVF = 2;
	localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;
	// Context: {pclath7, fsr1, fsr0, bsr6, status8, w8}; timeout and power-down dropped
	localparam logic [CTX_W-1:0] CTX_KEEP = ~((61'h1 << 12) | (61'h1 << 11));
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 50;
	localparam int TCY_NS = 200;
	localparam int Q_PER_TCY = TCY_NS / CLK_NS;
	localparam logic [1:0] Q1_PHASE = 2'h0;
	localparam logic [1:0] Q_LAST = 2'(Q_PER_TCY - 1);
	// ****************************************
	// Types and helpers
	// ****************************************
	typedef enum logic [2:0] {
		MIL_IDLE = 3'b001,
		MIL_FLUSH = 3'b010,
		MIL_VECTOR = 3'b100
	} mil_state_type;
	// Byte address to register index
	function automatic logic [IDX_W-1:0] mil_idx(input logic [15:0] a);
		return a[IDX_W+1:2];
	endfunction
endpackage
`default_nettype wire

// [core/mil_flag_if.sv]
// Interface between the control logic and the flag bank
`timescale 1ns/1ns
`default_nettype none
interface mil_flag_if;
	import mil_pkg::*;
	logic wr_flag;
	logic wr_en;
	logic [3:0] wr_sel;
	logic [REG_W-1:0] wr_data;
	logic [FLAG_W-1:0] set;
	logic [FLAG_W-1:0] flags;
	logic [FLAG_W-1:0] en;
	modport bank(input wr_flag, input wr_en, input wr_sel, input wr_data, input set,
		output flags, output en);
	modport ctrl(output wr_flag, output wr_en, output wr_sel, output wr_data, output set,
		input flags, input en);
endinterface
`default_nettype wire

// [core/mil_flag_bank.sv]
// Flag and enable register bank
`timescale 1ns/1ns
`default_nettype none
module mil_flag_bank
	import mil_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	mil_flag_if.bank fi
);
	logic [FLAG_W-1:0] flags_q;
	logic [FLAG_W-1:0] en_q;

	// ****************************************
	// Flags
	// ****************************************
	// R4 R10 R19 sticky flags, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= '0;
		end else begin
			for (int i = 0; i < NUM_FLAG_REGS; i++) begin
				flags_q[i*REG_W +: REG_W] <= ((fi.wr_flag && fi.wr_sel == 4'(i)) ?
					fi.wr_data : flags_q[i*REG_W +: REG_W]) | fi.set[i*REG_W +: REG_W];
			end
		end
	end

	// R1 enables cleared by reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= '0;
		end else begin
			for (int i = 0; i < NUM_FLAG_REGS; i++) begin
				if (fi.wr_en && fi.wr_sel == 4'(i)) begin
					en_q[i*REG_W +: REG_W] <= fi.wr_data;
				end
			end
		end
	end

	assign fi.flags = flags_q;
	assign fi.en = en_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_flag_set;
		(|fi.set) |=> ((flags_q & $past(fi.set)) == $past(fi.set));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event did not set flag"); // R10
	property p_flag_hold;
		!fi.wr_flag |=> ((flags_q & $past(flags_q)) == $past(flags_q));
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost without write"); // R19
endmodule
`default_nettype wire

// [core/mil_irq_ctrl.sv]
// Interrupt control top: APB registers, sampling, vectoring, stack, shadow
`timescale 1ns/1ns
`default_nettype none
module mil_irq_ctrl
	import mil_pkg::*;
#(
	parameter int STACK_DEPTH = 16
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [FLAG_W-1:0] periph_evt,
	input wire logic ext_pin,
	input wire logic [PC_W-1:0] core_pc,
	input wire logic [CTX_W-1:0] core_ctx,
	input wire logic core_return_from_isr_instr,
	output logic q1_tick,
	output logic flush_prefetch,
	output logic pc_load,
	output logic [PC_W-1:0] pc_value,
	output logic ctx_restore,
	output logic [CTX_W-1:0] ctx_value,
	output logic irq
);
	localparam int SP_W = $clog2(STACK_DEPTH + 1);
	localparam int STK_AW = $clog2(STACK_DEPTH);

	mil_flag_if fi();

	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic gie_q, periph_group_irq_enable_q, edge_q;
	logic [1:0] q_q;
	logic q1_tick_q;
	logic pin_prev_q, pin_seen_q;
	logic return_from_isr_instr_pend_q;
	mil_state_type state_q;
	logic [PC_W-1:0] stk_q [STACK_DEPTH];
	logic [SP_W-1:0] sp_q;
	logic [CTX_W-1:0] shadow_q;
	logic flush_q;
	logic pc_load_q;
	logic [PC_W-1:0] pc_value_q;
	logic ctx_restore_q;
	logic [CTX_W-1:0] ctx_value_q;
	logic [STAT_W-1:0] stat_q, mask_q;
	logic irq_q;

	logic [IDX_W-1:0] idx;
	logic access, done, wr, rd;
	logic hit_ctl, hit_flag, hit_en, hit_stat, hit_mask, hit_any;
	logic [IDX_W-1:0] sel_full;
	logic [REG_W-1:0] rdata;
	logic q1, ext_edge, pend0, pendp, pend_any;
	logic accept, do_return, do_push, ovf;
	logic [STAT_W-1:0] stat_set;

	// ****************************************
	// APB decode
	// ****************************************
	// Address decode and handshake terms
	assign idx = mil_idx(paddr);
	assign access = psel & penable;
	assign done = access & pready_q;
	assign wr = done & pwrite;
	assign rd = done & ~pwrite;
	assign hit_ctl = (idx == IDX_INTCTL);
	assign hit_flag = (idx >= IDX_FLAG0) && (idx < IDX_FLAG0 + 12'(NUM_FLAG_REGS));
	assign hit_en = (idx >= IDX_EN0) && (idx < IDX_EN0 + 12'(NUM_FLAG_REGS));
	assign hit_stat = (idx == IDX_STAT);
	assign hit_mask = (idx == IDX_MASK);
	assign hit_any = hit_ctl | hit_flag | hit_en | hit_stat | hit_mask;
	assign sel_full = hit_flag ? (idx - IDX_FLAG0) : (idx - IDX_EN0);

	// Read data mux
	always_comb begin
		rdata = '0;
		if (hit_ctl) begin
			rdata[GIE_BIT] = gie_q;
			rdata[PERIPH_GROUP_IRQ_ENABLE_BIT] = periph_group_irq_enable_q;
			rdata[EDGE_BIT] = edge_q;
		end else if (hit_flag) begin
			rdata = fi.flags[sel_full[3:0]*REG_W +: REG_W];
		end else if (hit_en) begin
			rdata = fi.en[sel_full[3:0]*REG_W +: REG_W];
		end else if (hit_stat) begin
			rdata[STAT_W-1:0] = stat_q;
		end else if (hit_mask) begin
			rdata[STAT_W-1:0] = mask_q;
		end
	end

	// One wait state, answer registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= access & ~pready_q;
			pslverr_q <= access & ~pready_q & ~hit_any;
			prdata_q <= (access & ~pready_q) ? {24'h000000, rdata} : 32'h00000000;
		end
	end

	// Flag bank connection
	assign fi.wr_flag = wr & hit_flag;
	assign fi.wr_en = wr & hit_en;
	assign fi.wr_sel = sel_full[3:0];
	assign fi.wr_data = pwdata[REG_W-1:0];
	assign fi.set = periph_evt | {{(FLAG_W-1){1'b0}}, ext_edge};

	mil_flag_bank u_bank (
		.pclk(pclk),
		.presetn(presetn),
		.fi(fi)
	);

	// ****************************************
	// Control register
	// ****************************************
	// R1 R5 R9 global enable, hardware after software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gie_q <= INTCTL_RST[GIE_BIT];
			periph_group_irq_enable_q <= INTCTL_RST[PERIPH_GROUP_IRQ_ENABLE_BIT];
			edge_q <= INTCTL_RST[EDGE_BIT];
		end else begin
			if (wr && hit_ctl) begin
				gie_q <= pwdata[GIE_BIT];
				periph_group_irq_enable_q <= pwdata[PERIPH_GROUP_IRQ_ENABLE_BIT];
				edge_q <= pwdata[EDGE_BIT];
			end
			if (accept) begin
				gie_q <= 1'b0;
			end
			if (do_return) begin
				gie_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// Instruction cycle phases
	// ****************************************
	// R12 quarter-cycle counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_q <= Q1_PHASE;
			q1_tick_q <= 1'b0;
		end else begin
			q_q <= (q_q == Q_LAST) ? Q1_PHASE : 2'(q_q + 2'h1);
			q1_tick_q <= (q_q == Q_LAST);
		end
	end
	assign q1 = (q_q == Q1_PHASE);

	// ****************************************
	// External pin
	// ****************************************
	// R18 R14 edge select, flag set any phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_q <= 1'b0;
			pin_seen_q <= 1'b0;
		end else begin
			pin_prev_q <= ext_pin;
			pin_seen_q <= 1'b1; // No edge before first sample
		end
	end
	assign ext_edge = pin_seen_q & (edge_q ? (ext_pin & ~pin_prev_q) : (~ext_pin & pin_prev_q));

	// ****************************************
	// Pending and acceptance
	// ****************************************
	// R17 first register skips group enable
	assign pend0 = |(fi.flags[REG_W-1:0] & fi.en[REG_W-1:0]);
	// R3 other registers need group enable
	assign pendp = periph_group_irq_enable_q & |(fi.flags[FLAG_W-1:REG_W] & fi.en[FLAG_W-1:REG_W]);
	assign pend_any = pend0 | pendp;

	// Return request held until a Q1 in the idle state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			return_from_isr_instr_pend_q <= 1'b0;
		end else begin
			return_from_isr_instr_pend_q <= core_return_from_isr_instr | (return_from_isr_instr_pend_q & ~do_return);
		end
	end

	// R2 R7 R11 R12 accept only at Q1 with global
	assign accept = q1 & (state_q == MIL_IDLE) & ~return_from_isr_instr_pend_q & gie_q & pend_any;
	assign do_return = q1 & (state_q == MIL_IDLE) & return_from_isr_instr_pend_q;
	assign do_push = q1 & (state_q == MIL_FLUSH);
	assign ovf = do_push & (sp_q == SP_W'(STACK_DEPTH));

	// R13 flush cycle, push, then vector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= MIL_IDLE;
		end else begin
			case (state_q)
				MIL_IDLE: begin
					if (accept) begin
						state_q <= MIL_FLUSH;
					end
				end
				MIL_FLUSH: begin
					if (q1) begin
						state_q <= MIL_VECTOR;
					end
				end
				MIL_VECTOR: begin
					if (q1) begin
						state_q <= MIL_IDLE;
					end
				end
				default: begin
					state_q <= MIL_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Stack and shadow
	// ****************************************
	// R5 R9 push on entry, pop on return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_q <= '0;
		end else if (do_push && !ovf) begin
			sp_q <= SP_W'(sp_q + 1'b1);
		end else if (do_return && sp_q != '0) begin
			sp_q <= SP_W'(sp_q - 1'b1);
		end
	end

	// Stack storage
	always_ff @(posedge pclk) begin
		if (do_push && !ovf) begin
			stk_q[sp_q[STK_AW-1:0]] <= core_pc;
		end
	end

	// R6 R16 shadow copy on entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shadow_q <= '0;
		end else if (do_push) begin
			shadow_q <= core_ctx & CTX_KEEP;
		end
	end

	// ****************************************
	// Core outputs
	// ****************************************
	// R5 R6 R9 registered redirections
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_q <= 1'b0;
			pc_load_q <= 1'b0;
			pc_value_q <= '0;
			ctx_restore_q <= 1'b0;
			ctx_value_q <= '0;
		end else begin
			flush_q <= accept;
			pc_load_q <= (q1 & (state_q == MIL_VECTOR)) | do_return;
			ctx_restore_q <= do_return;
			if (do_return) begin
				pc_value_q <= (sp_q != '0) ? stk_q[STK_AW'(sp_q - 1'b1)] : '0;
				ctx_value_q <= shadow_q;
			end else if (q1 && state_q == MIL_VECTOR) begin
				pc_value_q <= VECTOR_ADDR;
			end
		end
	end

	// ****************************************
	// Status, mask, interrupt line
	// ****************************************
	assign stat_set = {ovf, do_return, accept};

	// Sticky status, read clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			stat_q <= ((rd && hit_stat) ? '0 : stat_q) | stat_set;
			if (wr && hit_mask) begin
				mask_q <= pwdata[STAT_W-1:0];
			end
			irq_q <= |(stat_q & mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign q1_tick = q1_tick_q;
	assign flush_prefetch = flush_q;
	assign pc_load = pc_load_q;
	assign pc_value = pc_value_q;
	assign ctx_restore = ctx_restore_q;
	assign ctx_value = ctx_value_q;
	assign irq = irq_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_reset_off;
		$rose(presetn) |-> !gie_q && !periph_group_irq_enable_q && fi.en == '0;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("enabled after reset"); // R1
	property p_need_enable;
		flush_q |-> $past(gie_q) && $past(pend_any);
	endproperty
	a_need_enable: assert property (p_need_enable) else $error("vector without enable"); // R2
	property p_group;
		flush_q && !$past(pend0) |-> $past(periph_group_irq_enable_q);
	endproperty
	a_group: assert property (p_group) else $error("peripheral vector without group"); // R3
	property p_entry;
		flush_q |-> !gie_q ##4 (sp_q != $past(sp_q, 4) || stat_q[ST_OVF]);
	endproperty
	a_entry: assert property (p_entry) else $error("entry did not clear or push"); // R5
	property p_vector;
		flush_q |-> ##8 (pc_load_q && pc_value_q == VECTOR_ADDR);
	endproperty
	a_vector: assert property (p_vector) else $error("vector not loaded"); // R6
	property p_masked;
		!gie_q |=> !flush_q;
	endproperty
	a_masked: assert property (p_masked) else $error("vectored with global clear"); // R7
	property p_return;
		ctx_restore_q |-> pc_load_q && gie_q && ctx_value_q == $past(shadow_q);
	endproperty
	a_return: assert property (p_return) else $error("return incomplete"); // R9
	property p_q1;
		flush_q |-> $past(q_q) == Q1_PHASE;
	endproperty
	a_q1: assert property (p_q1) else $error("accepted outside Q1"); // R12
	property p_shadow;
		state_q == MIL_VECTOR && $past(state_q) == MIL_FLUSH |->
			shadow_q == ($past(core_ctx) & CTX_KEEP);
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadow copy wrong"); // R16
	property p_pin;
		ext_edge |=> fi.flags[0];
	endproperty
	a_pin: assert property (p_pin) else $error("pin edge lost"); // R18
	c_accept: cover property (flush_q);
	c_return: cover property (ctx_restore_q);
	c_ovf: cover property (stat_q[ST_OVF]);
endmodule
`default_nettype wire

// [testbench/mil_core_model.sv]
// Behavioural processor core facing the interrupt logic
`timescale 1ns/1ns
`default_nettype none
module mil_core_model
	import mil_pkg::*;
#(
	parameter logic [CTX_W-1:0] CTX_INIT = '1
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic q1_tick,
	input wire logic flush_prefetch,
	input wire logic pc_load,
	input wire logic [PC_W-1:0] pc_value,
	input wire logic ret_go,
	output logic [PC_W-1:0] core_pc,
	output logic [CTX_W-1:0] core_ctx,
	output logic core_return_from_isr_instr
);
	logic stall_q;

	// ********
	// Program counter
	// ********
	// Stalls after a flush so the pushed address is stable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_pc <= 15'h0100;
			stall_q <= 1'b0;
		end else if (pc_load) begin
			core_pc <= pc_value;
			stall_q <= 1'b0;
		end else if (flush_prefetch) begin
			stall_q <= 1'b1;
		end else if (q1_tick && !stall_q) begin
			core_pc <= core_pc + 15'h0001;
		end
	end

	// ********
	// Context and return
	// ********
	// Fixed context, so a restored copy is easy to predict
	assign core_ctx = CTX_INIT;

	// Return instruction as a one-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_return_from_isr_instr <= 1'b0;
		end else begin
			core_return_from_isr_instr <= ret_go;
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench of the interrupt logic
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import mil_pkg::*;
;
	localparam logic [CTX_W-1:0] CTX_PAT = 61'h1abcdef012345f78;
	logic pclk, presetn, psel, penable, pwrite, ext_pin, ret_go, last_err;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, core_return_from_isr_instr, q1_tick, flush_prefetch, pc_load, ctx_restore, irq;
	logic [FLAG_W-1:0] periph_evt;
	logic [PC_W-1:0] core_pc, pc_value;
	logic [CTX_W-1:0] core_ctx, ctx_value;
	int n_mismatch = 0;
	int checked = 0;

	// ********
	// Design and core model
	// ********
	mil_irq_ctrl #(.STACK_DEPTH(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_evt(periph_evt),
		.ext_pin(ext_pin), .core_pc(core_pc), .core_ctx(core_ctx),
		.core_return_from_isr_instr(core_return_from_isr_instr), .q1_tick(q1_tick), .flush_prefetch(flush_prefetch),
		.pc_load(pc_load), .pc_value(pc_value), .ctx_restore(ctx_restore),
		.ctx_value(ctx_value), .irq(irq));
	mil_core_model #(.CTX_INIT(CTX_PAT)) core (.pclk(pclk), .presetn(presetn),
		.q1_tick(q1_tick), .flush_prefetch(flush_prefetch), .pc_load(pc_load),
		.pc_value(pc_value), .ret_go(ret_go), .core_pc(core_pc), .core_ctx(core_ctx),
		.core_return_from_isr_instr(core_return_from_isr_instr));

	// Clock at 20 MHz
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// ********
	// Shared tasks
	// ********
	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, then one idle edge
	task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			stop_test();
		end
		@(posedge pclk);
	endtask

	task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, i, d, r);
	endtask

	task automatic rd(input logic [IDX_W-1:0] i, output logic [31:0] r);
		apb(1'b0, i, 32'h0, r);
	endtask

	// Waits for flush (0), pc load (1) or context restore (2)
	task automatic wait_out(input int sel, input int max, output logic hit, output int cyc);
		hit = 1'b0;
		cyc = 0;
		while (!hit && cyc < max) begin
			@(posedge pclk);
			cyc++;
			hit = ((sel == 0) ? flush_prefetch : (sel == 1) ? pc_load : ctx_restore) === 1'b1;
		end
	endtask

	task automatic do_return();
		logic hit;
		int cyc;
		ret_go <= 1'b1;
		@(posedge pclk);
		ret_go <= 1'b0;
		wait_out(2, 24, hit, cyc);
		chk(hit, 1'b1);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		logic [31:0] r;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({flush_prefetch, pc_load, irq}, 3'h0);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(q1_tick, 1'b0);
		@(posedge pclk);
		chk(q1_tick, 1'b1);
		rd(IDX_FLAG0, r);
		chk(r, 32'h0);
		rd(IDX_INTCTL, r);
		chk(r, {24'h0, INTCTL_RST});
		rd(IDX_EN0, r);
		chk(r, 32'h0);
		rd(12'h0ff, r);
		chk({last_err, r}, {1'b1, 32'h0});
	endtask

	task automatic t_poll();
		logic [31:0] r;
		logic hit;
		int cyc;
		logic [PC_W-1:0] pc_saved;
		ext_pin <= 1'b1;
		wait_out(0, 16, hit, cyc);
		chk(hit, 1'b0);
		repeat (40) @(posedge pclk);
		rd(IDX_FLAG0, r);
		chk(r, 32'h1);
		wr(IDX_EN0, 32'h1);
		wait_out(0, 16, hit, cyc);
		chk(hit, 1'b0);
		wr(IDX_INTCTL, 32'h81);
		wait_out(0, 16, hit, cyc);
		chk(hit, 1'b1);
		pc_saved = core_pc;
		wait_out(1, 16, hit, cyc);
		chk({hit, pc_value}, {1'b1, VECTOR_ADDR});
		rd(IDX_INTCTL, r);
		chk(r, 32'h01);
		rd(IDX_FLAG0, r);
		chk(r, 32'h1);
		wr(IDX_FLAG0, 32'h0);
		do_return();
		chk(pc_value, pc_saved);
		chk(ctx_value, CTX_PAT & CTX_KEEP);
		rd(IDX_INTCTL, r);
		chk(r, 32'h81);
		wait_out(0, 16, hit, cyc);
		chk(hit, 1'b0);
	endtask

	task automatic t_latency();
		logic hit;
		int cyc;
		ext_pin <= 1'b0;
		wait_out(0, 16, hit, cyc);
		chk(hit, 1'b0);
		wr(IDX_INTCTL, 32'h80);
		ext_pin <= 1'b1;
		wait_out(0, 16, hit, cyc);
		chk(hit, 1'b0);
		ext_pin <= 1'b0;
		wait_out(1, 40, hit, cyc);
		chk({hit, cyc <= 5 * Q_PER_TCY}, 2'h3);
		wr(IDX_FLAG0, 32'h0);
		do_return();
	endtask

	task automatic t_group();
		logic [31:0] r;
		logic hit;
		int cyc;
		wr(IDX_EN0, 32'h0);
		wr(IDX_EN0 + 12'h001, 32'h1);
		wr(IDX_INTCTL, 32'h81);
		periph_evt <= {1'b1, {(FLAG_W-10){1'b0}}, 1'b1, 8'h00};
		@(posedge pclk);
		periph_evt <= '0;
		wait_out(0, 16, hit, cyc);
		chk(hit, 1'b0);
		rd(IDX_FLAG0 + 12'h001, r);
		chk(r, 32'h1);
		rd(IDX_FLAG0 + 12'h008, r);
		chk(r, 32'h80);
		rd(IDX_FLAG0 + 12'h009, r);
		chk({last_err, r}, {1'b1, 32'h0});
		wr(IDX_FLAG0 + 12'h008, 32'h0);
		wr(IDX_INTCTL, 32'hc1);
		wait_out(0, 16, hit, cyc);
		chk(hit, 1'b1);
		wr(IDX_FLAG0 + 12'h001, 32'h0);
		do_return();
	endtask

	task automatic t_status();
		logic [31:0] r;
		logic hit;
		int cyc;
		chk(irq, 1'b0);
		wr(IDX_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		rd(IDX_STAT, r);
		chk(r, 32'h3);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		wr(IDX_STAT, 32'h7);
		rd(IDX_STAT, r);
		chk({last_err, r}, 33'h0);
		// Seventeen entries without return overflow the stack
		wr(IDX_INTCTL, 32'h41);
		wr(IDX_EN0, 32'h1);
		ext_pin <= 1'b1;
		for (int i = 0; i <= 16; i++) begin
			wr(IDX_INTCTL, 32'hc1);
			wait_out(1, 24, hit, cyc);
			chk(hit, 1'b1);
		end
		rd(IDX_STAT, r);
		chk(r, 32'h5);
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		periph_evt = '0;
		ext_pin = 1'b0;
		ret_go = 1'b0;
		last_err = 1'b0;
		t_reset();
		t_poll();
		t_latency();
		t_group();
		t_status();
		wr(IDX_INTCTL, 32'hc1);
		t_reset();
		stop_test();
	end
endmodule
`default_nettype wire
